/* File: pkg/bcs_pkg.sv */
package bcs_pkg;

  // =====================================================
  // time base
  // =====================================================
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned TOGGLE_US = 500;
  localparam int unsigned TOGGLE_CYC = CLK_HZ / 1000000 * TOGGLE_US;

  // =====================================================
  // delays in milliseconds (one tick per millisecond)
  // =====================================================
  localparam int unsigned START_THERM_MS = 200;
  localparam int unsigned START_POWER_MS = 150;
  localparam int unsigned TRK_SHORT_MS = 1;
  localparam int unsigned QUAL_MS = 50;
  localparam int unsigned TRK_HOURS = 2;
  localparam int unsigned MAIN_HOURS = 10;
  localparam int unsigned MS_PER_HOUR = 3600000;
  localparam int unsigned TRK_LIMIT_MS = TRK_HOURS * MS_PER_HOUR;
  localparam int unsigned MAIN_LIMIT_MS = MAIN_HOURS * MS_PER_HOUR;

  localparam int TIMER_W = 26;
  localparam int QUAL_W = 8;

  // =====================================================
  // current request codes
  // =====================================================
  localparam logic [1:0] CUR_OFF = 2'h0;
  localparam logic [1:0] CUR_TENTH = 2'h1;
  localparam logic [1:0] CUR_HALF = 2'h2;
  localparam logic [1:0] CUR_FULL = 2'h3;

  // temperature zones
  typedef enum logic [4:0] {
    BCS_ZONE_COLD_STOP = 5'h01,
    BCS_ZONE_COOL      = 5'h02,
    BCS_ZONE_NORMAL    = 5'h04,
    BCS_ZONE_WARM      = 5'h08,
    BCS_ZONE_HOT_STOP  = 5'h10
  } bcs_zone_t;

  typedef enum logic [5:0] {
    BCS_ST_IDLE     = 6'h01,
    BCS_ST_START    = 6'h02,
    BCS_ST_TRICKLE  = 6'h04,
    BCS_ST_MAIN     = 6'h08,
    BCS_ST_DONE     = 6'h10,
    BCS_ST_ERROR    = 6'h20
  } bcs_state_t;

endpackage

/* File: pkg/bcs_qual_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface bcs_qual_if;
  logic tick;
  logic raw;
  logic clr;
  logic held;
  modport owner (output tick, output raw, output clr, input held);
  modport filt (input tick, input raw, input clr, output held);
endinterface
`default_nettype wire

/* File: src/bcs_qual.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// persistence filter: held rises after raw stays high for limit ticks
// =====================================================
module bcs_qual
  import bcs_pkg::*;
#(
  parameter int unsigned LIMIT = QUAL_MS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // filter port
  bcs_qual_if.filt q
);
  logic [QUAL_W-1:0] cnt;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || q.clr || !q.raw) begin
      cnt <= '0;
      q.held <= 1'b0;
    end else if (q.tick && !q.held) begin
      if (cnt == QUAL_W'(LIMIT - 1)) begin
        q.held <= 1'b1;
      end
      cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: src/bcs_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter bit RECHARGE_EN = 1'b1,
  parameter bit ERR_BLINK = 1'b1,
  parameter int unsigned ZONES = 4,
  parameter int unsigned TRK_LIMIT = TRK_LIMIT_MS,
  parameter int unsigned MAIN_LIMIT = MAIN_LIMIT_MS,
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // supply and battery presence
  input wire logic power_good_i,
  input wire logic therm_present_i,
  // battery and chip temperature comparators
  input wire logic above_trickle_i,
  input wire logic cv_reached_i,
  input wire logic below_finish_i,
  input wire logic below_recharge_i,
  input wire logic over_voltage_i,
  input wire logic over_current_i,
  input wire logic chip_hot_i,
  input wire logic chip_cool_i,
  // thermistor comparators
  input wire logic below_0c_i,
  input wire logic below_10c_i,
  input wire logic above_45c_i,
  input wire logic above_60c_i,
  // charger control
  output logic charge_en_o,
  output logic [1:0] current_req_o,
  output logic cv_low_o,
  // status pin, open drain
  output logic status_pin_o,
  output logic status_pin_oe_o
);

  // =====================================================
  // input synchronisers
  // =====================================================
  localparam int NIN = 14;
  logic [NIN-1:0] sync_a;
  logic [NIN-1:0] sync_b;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {power_good_i, therm_present_i, above_trickle_i, cv_reached_i,
                 below_finish_i, below_recharge_i, over_voltage_i, over_current_i,
                 chip_hot_i, chip_cool_i, below_0c_i, below_10c_i, above_45c_i,
                 above_60c_i};
      sync_b <= sync_a;
    end
  end

  logic pwr, therm, trk_ok, cv_ok, fin_ok, rchg, ovp, ocp, hot, cool;
  logic c0, c10, h45, h60;
  assign {pwr, therm, trk_ok, cv_ok, fin_ok, rchg, ovp, ocp, hot, cool,
          c0, c10, h45, h60} = sync_b;

  // =====================================================
  // millisecond time base
  // =====================================================
  logic [15:0] pre;
  logic tick;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pre <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (pre == 16'(TICK_CYCLES - 1));
      pre <= (pre == 16'(TICK_CYCLES - 1)) ? '0 : pre + 16'h0001;
    end
  end

  // =====================================================
  // presence edges
  // =====================================================
  logic pwr_d, therm_d;
  logic pwr_rise, therm_rise, lost;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pwr_d <= 1'b0;
      therm_d <= 1'b0;
    end else begin
      pwr_d <= pwr;
      therm_d <= therm;
    end
  end

  assign pwr_rise = pwr && !pwr_d;
  assign therm_rise = therm && !therm_d;
  assign lost = !pwr || !therm;

  // =====================================================
  // state and counters
  // =====================================================
  bcs_state_t state;
  bcs_state_t next_state;
  logic [TIMER_W-1:0] dly;
  logic [TIMER_W-1:0] dly_limit;
  logic [TIMER_W-1:0] trk_tmr;
  logic [TIMER_W-1:0] main_tmr;
  logic paused;

  // persistence filters
  bcs_qual_if q_trk();
  bcs_qual_if q_fin();
  bcs_qual_if q_ovp();
  bcs_qual_if q_hot();
  bcs_qual_if q_cool();

  assign q_trk.tick = tick;
  assign q_trk.raw = trk_ok;
  assign q_trk.clr = (state != BCS_ST_TRICKLE);
  assign q_fin.tick = tick;
  assign q_fin.raw = cv_ok && fin_ok;
  assign q_fin.clr = (state != BCS_ST_MAIN);
  assign q_ovp.tick = tick;
  assign q_ovp.raw = ovp;
  assign q_ovp.clr = !(state == BCS_ST_TRICKLE || state == BCS_ST_MAIN);
  assign q_hot.tick = tick;
  assign q_hot.raw = hot;
  assign q_hot.clr = 1'b0;
  assign q_cool.tick = tick;
  assign q_cool.raw = cool;
  assign q_cool.clr = 1'b0;

  bcs_qual u_q_trk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .q(q_trk.filt));
  bcs_qual u_q_fin (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .q(q_fin.filt));
  bcs_qual u_q_ovp (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .q(q_ovp.filt));
  bcs_qual u_q_hot (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .q(q_hot.filt));
  bcs_qual u_q_cool (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .q(q_cool.filt));

  // =====================================================
  // chip overtemperature latch
  // =====================================================
  logic shutdown;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      shutdown <= 1'b0;
    end else if (q_hot.held) begin
      shutdown <= 1'b1;
    end else if (q_cool.held) begin
      shutdown <= 1'b0;
    end
  end

  // =====================================================
  // temperature zone with 50ms qualification
  // =====================================================
  function automatic bcs_zone_t raw_zone(input logic b0, input logic b10,
                                         input logic a45, input logic a60);
    bcs_zone_t z;
    z = BCS_ZONE_NORMAL;
    if (b0) begin
      z = BCS_ZONE_COLD_STOP;
    end else if (b10 && ZONES >= 3) begin
      z = BCS_ZONE_COOL;
    end else if (a45 && ZONES < 4) begin
      z = BCS_ZONE_HOT_STOP;
    end else if (a60) begin
      z = BCS_ZONE_HOT_STOP;
    end else if (a45) begin
      z = BCS_ZONE_WARM;
    end
    return z;
  endfunction

  bcs_zone_t zone;
  bcs_zone_t zone_cand;
  logic [QUAL_W-1:0] zone_cnt;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      zone <= BCS_ZONE_NORMAL;
      zone_cand <= BCS_ZONE_NORMAL;
      zone_cnt <= '0;
    end else if (raw_zone(c0, c10, h45, h60) != zone_cand) begin
      zone_cand <= raw_zone(c0, c10, h45, h60);
      zone_cnt <= '0;
    end else if (zone_cand == zone) begin
      zone_cnt <= '0;
    end else if (tick) begin
      if (zone_cnt == QUAL_W'(QUAL_MS - 1)) begin
        zone <= zone_cand;
        zone_cnt <= '0;
      end else begin
        zone_cnt <= zone_cnt + 1'b1;
      end
    end
  end

  assign paused = shutdown || zone == BCS_ZONE_COLD_STOP || zone == BCS_ZONE_HOT_STOP;

  // =====================================================
  // sequencer
  // =====================================================
  logic start_from_therm;
  logic trk_long;

  always_comb begin
    next_state = state;
    dly_limit = TIMER_W'(START_POWER_MS);
    if (start_from_therm) begin
      dly_limit = TIMER_W'(START_THERM_MS);
    end
    case (state)
      BCS_ST_IDLE: begin
        if (pwr && therm) begin
          next_state = BCS_ST_START;
        end
      end
      BCS_ST_START: begin
        if (lost) begin
          next_state = BCS_ST_IDLE;
        end else if (tick && dly == dly_limit - 1'b1) begin
          next_state = BCS_ST_TRICKLE;
        end
      end
      BCS_ST_TRICKLE: begin
        if (lost) begin
          next_state = BCS_ST_IDLE;
        end else if (q_ovp.held || ocp) begin
          next_state = BCS_ST_ERROR;
        end else if (!trk_long && tick && dly == TIMER_W'(TRK_SHORT_MS - 1)) begin
          next_state = BCS_ST_MAIN;
        end else if (trk_long && q_trk.held) begin
          next_state = BCS_ST_MAIN;
        end else if (trk_tmr >= TIMER_W'(TRK_LIMIT)) begin
          next_state = BCS_ST_ERROR;
        end
      end
      BCS_ST_MAIN: begin
        if (lost) begin
          next_state = BCS_ST_IDLE;
        end else if (q_ovp.held || ocp) begin
          next_state = BCS_ST_ERROR;
        end else if (q_fin.held) begin
          next_state = BCS_ST_DONE;
        end else if (main_tmr >= TIMER_W'(MAIN_LIMIT)) begin
          next_state = BCS_ST_ERROR;
        end
      end
      BCS_ST_DONE: begin
        if (lost) begin
          next_state = BCS_ST_IDLE;
        end else if (RECHARGE_EN && rchg && zone != BCS_ZONE_COLD_STOP &&
                     zone != BCS_ZONE_HOT_STOP) begin
          next_state = BCS_ST_START;
        end
      end
      BCS_ST_ERROR: begin
        if (lost) begin
          next_state = BCS_ST_IDLE;
        end
      end
      default: begin
        next_state = BCS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= BCS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // which supply came last decides the start delay
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      start_from_therm <= 1'b0;
    end else if (state == BCS_ST_IDLE) begin
      start_from_therm <= therm_rise && !pwr_rise;
    end else if (state == BCS_ST_DONE) begin
      start_from_therm <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      trk_long <= 1'b0;
    end else if (state == BCS_ST_START) begin
      trk_long <= !trk_ok;
    end
  end

  // state-local delay counter
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || next_state != state) begin
      dly <= '0;
    end else if (tick) begin
      dly <= dly + 1'b1;
    end
  end

  // hold timers run even while paused
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || state == BCS_ST_IDLE || state == BCS_ST_START) begin
      trk_tmr <= '0;
      main_tmr <= '0;
    end else begin
      if (state == BCS_ST_TRICKLE && tick) begin
        trk_tmr <= trk_tmr + 1'b1;
      end
      if (state == BCS_ST_MAIN && tick) begin
        main_tmr <= main_tmr + 1'b1;
      end
    end
  end

  // =====================================================
  // outputs
  // =====================================================
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      charge_en_o <= 1'b0;
      current_req_o <= CUR_OFF;
      cv_low_o <= 1'b0;
    end else begin
      charge_en_o <= (next_state == BCS_ST_TRICKLE || next_state == BCS_ST_MAIN) && !paused;
      cv_low_o <= (zone == BCS_ZONE_WARM);
      if (paused) begin
        current_req_o <= CUR_OFF;
      end else if (next_state == BCS_ST_TRICKLE) begin
        current_req_o <= CUR_TENTH;
      end else if (next_state == BCS_ST_MAIN) begin
        current_req_o <= (zone == BCS_ZONE_COOL) ? CUR_HALF : CUR_FULL;
      end else begin
        current_req_o <= CUR_OFF;
      end
    end
  end

  logic [12:0] blink_cnt;
  logic blink;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || state != BCS_ST_ERROR) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == 13'(TOGGLE_CYC - 1)) begin
      blink_cnt <= '0;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 13'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    status_pin_o <= 1'b0;
    if (!rst_n_i) begin
      status_pin_oe_o <= 1'b0;
    end else begin
      case (state)
        BCS_ST_TRICKLE, BCS_ST_MAIN: status_pin_oe_o <= 1'b1;
        BCS_ST_DONE: status_pin_oe_o <= 1'b0;
        BCS_ST_ERROR: status_pin_oe_o <= ERR_BLINK && blink;
        default: status_pin_oe_o <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: tb/bcs_sequencer_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module bcs_sequencer_checker
  import bcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // watched inputs
  input wire logic power_good_i,
  input wire logic therm_present_i,
  input wire logic over_current_i,
  // watched outputs
  input wire logic charge_en_o,
  input wire logic [1:0] current_req_o,
  input wire logic status_pin_o,
  input wire logic status_pin_oe_o
);
  localparam int HALF_MIN = 4000;
  localparam int HALF_MAX = 6667;
  logic [31:0] up_cnt;
  logic [15:0] gap;
  logic [1:0] blinks;
  logic [7:0] ok_sh;
  logic oe_q;
  logic flip;
  assign flip = status_pin_oe_o != oe_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ======
  // helpers: supply-present age and status edge spacing
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !(power_good_i && therm_present_i)) begin
      up_cnt <= 32'h0;
    end else if (up_cnt != 32'hffffffff) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      oe_q <= 1'b0;
      gap <= 16'h0;
      blinks <= 2'h0;
      ok_sh <= 8'h0;
    end else begin
      oe_q <= status_pin_oe_o;
      ok_sh <= {ok_sh[6:0], power_good_i & therm_present_i};
      if (flip) begin
        gap <= 16'h0;
      end else if (gap != 16'hffff) begin
        gap <= gap + 16'h1;
      end
      if (charge_en_o || ok_sh != 8'hff) begin
        blinks <= 2'h0;
      end else if (flip && blinks != 2'h2) begin
        blinks <= blinks + 2'h1;
      end
    end
  end
  // ======
  // properties
  property p_pin_low;
    status_pin_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("status data bit not low");
  property p_en_then_oe;
    $rose(charge_en_o) |-> ##[0:2] status_pin_oe_o;
  endproperty
  a_en_then_oe: assert property (p_en_then_oe)
    else $error("status off while charging");
  property p_req_needs_en;
    !charge_en_o |-> current_req_o == CUR_OFF;
  endproperty
  a_req_needs_en: assert property (p_req_needs_en)
    else $error("current requested with driver off");
  property p_supply_loss;
    $fell(power_good_i) |-> ##[1:30] (!charge_en_o && !status_pin_oe_o);
  endproperty
  a_supply_loss: assert property (p_supply_loss)
    else $error("still active after supply loss");
  property p_no_therm_no_start;
    !therm_present_i [*5] |-> !$rose(charge_en_o);
  endproperty
  a_no_therm_no_start: assert property (p_no_therm_no_start)
    else $error("charge began without thermistor");
  property p_start_delay;
    $rose(charge_en_o) |-> up_cnt >= 149 * TICK_CYCLES;
  endproperty
  a_start_delay: assert property (p_start_delay)
    else $error("charge began too early");
  property p_overcurrent;
    over_current_i && charge_en_o |-> ##[1:15] !charge_en_o;
  endproperty
  a_overcurrent: assert property (p_overcurrent)
    else $error("overcurrent did not stop charge");
  property p_blink_rate;
    flip && blinks == 2'h2 |-> gap >= HALF_MIN && gap <= HALF_MAX;
  endproperty
  a_blink_rate: assert property (p_blink_rate)
    else $error("error blink rate out of range");
endmodule
bind bcs_sequencer bcs_sequencer_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) bcs_sequencer_checker_i (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .power_good_i(power_good_i),
  .therm_present_i(therm_present_i),
  .over_current_i(over_current_i),
  .charge_en_o(charge_en_o),
  .current_req_o(current_req_o),
  .status_pin_o(status_pin_o),
  .status_pin_oe_o(status_pin_oe_o)
);
`default_nettype wire

/* File: tb/bcs_battery_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bcs_battery_model (
  // clock
  input wire logic mclk_i,
  // cell conditions set by the bench
  input wire logic [12:0] vbat_mv_i,
  input wire logic taper_i,
  input wire logic surge_i,
  input wire logic signed [7:0] temp_c_i,
  input wire logic die_hot_i,
  input wire logic charge_en_i,
  // comparator results
  output logic above_trickle_o,
  output logic cv_reached_o,
  output logic below_finish_o,
  output logic below_recharge_o,
  output logic over_voltage_o,
  output logic over_current_o,
  output logic chip_hot_o,
  output logic chip_cool_o,
  output logic below_0c_o,
  output logic below_10c_o,
  output logic above_45c_o,
  output logic above_60c_o
);
  // comparators settle on the clock like the real analog front end
  always_ff @(posedge mclk_i) begin
    above_trickle_o <= vbat_mv_i >= 13'd2900;
    cv_reached_o <= vbat_mv_i >= 13'd4200;
    below_finish_o <= !charge_en_i || taper_i;
    below_recharge_o <= vbat_mv_i <= 13'd3900;
    over_voltage_o <= vbat_mv_i >= 13'd4450;
    over_current_o <= surge_i;
    chip_hot_o <= die_hot_i;
    chip_cool_o <= !die_hot_i;
    below_0c_o <= temp_c_i <= 8'sd0;
    below_10c_o <= temp_c_i <= 8'sd10;
    above_45c_o <= temp_c_i >= 8'sd45;
    above_60c_o <= temp_c_i >= 8'sd60;
  end
endmodule
`default_nettype wire

/* File: tb/bcs_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bcs_sequencer_tb;
  import bcs_pkg::*;
  localparam int unsigned TICK = 10;
  localparam int unsigned TRK = 500;
  localparam int unsigned MAIN = 1000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic power_good = 1'b0;
  logic therm_present = 1'b0;
  logic [12:0] vbat_mv = 13'd2000;
  logic taper = 1'b0;
  logic surge = 1'b0;
  logic signed [7:0] temp_c = 8'sd25;
  logic die_hot = 1'b0;
  logic a_trk, cv_ok, b_fin, b_rch, o_v, o_c, c_hot, c_cool, b0, b10, a45, a60;
  logic charge_en, status_pin, status_oe, cv_low;
  logic [1:0] current_req;
  int num_errors = 0;
  int samples_checked = 0;
  always #50 mclk = ~mclk;
  bcs_sequencer #(.TRK_LIMIT(TRK), .MAIN_LIMIT(MAIN), .TICK_CYCLES(TICK)) bcs_sequencer_i (
    .mclk_i(mclk), .rst_n_i(rst_n), .power_good_i(power_good),
    .therm_present_i(therm_present), .above_trickle_i(a_trk), .cv_reached_i(cv_ok),
    .below_finish_i(b_fin), .below_recharge_i(b_rch), .over_voltage_i(o_v),
    .over_current_i(o_c), .chip_hot_i(c_hot), .chip_cool_i(c_cool), .below_0c_i(b0),
    .below_10c_i(b10), .above_45c_i(a45), .above_60c_i(a60), .charge_en_o(charge_en),
    .current_req_o(current_req), .cv_low_o(cv_low), .status_pin_o(status_pin),
    .status_pin_oe_o(status_oe));
  bcs_battery_model bcs_battery_model_i (
    .mclk_i(mclk), .vbat_mv_i(vbat_mv), .taper_i(taper), .surge_i(surge),
    .temp_c_i(temp_c), .die_hot_i(die_hot), .charge_en_i(charge_en),
    .above_trickle_o(a_trk), .cv_reached_o(cv_ok), .below_finish_o(b_fin),
    .below_recharge_o(b_rch), .over_voltage_o(o_v), .over_current_o(o_c),
    .chip_hot_o(c_hot), .chip_cool_o(c_cool), .below_0c_o(b0), .below_10c_o(b10),
    .above_45c_o(a45), .above_60c_o(a60));
  // ======
  // helpers
  task automatic wait_ms(input int n);
    repeat (n * TICK) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // therm_last: supply first, thermistor attached last
  task automatic boot(input logic [12:0] mv, input bit therm_last);
    @(posedge mclk);
    power_good <= 1'b0;
    therm_present <= 1'b0;
    vbat_mv <= mv;
    wait_ms(5);
    @(posedge mclk);
    power_good <= therm_last;
    therm_present <= !therm_last;
    wait_ms(10);
    @(posedge mclk);
    power_good <= 1'b1;
    therm_present <= 1'b1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ======
  // scenarios
  task automatic t_start();
    boot(13'd2000, 1'b0);
    wait_ms(146);
    chk({charge_en, status_oe}, 2'h0);
    wait_ms(8);
    chk({charge_en, status_oe}, 2'h3);
    chk(current_req, CUR_TENTH);
    @(posedge mclk);
    vbat_mv <= 13'd3000;
    wait_ms(47);
    chk(current_req, CUR_TENTH);
    wait_ms(6);
    chk(current_req, CUR_FULL);
    @(posedge mclk);
    vbat_mv <= 13'd4200;
    taper <= 1'b1;
    wait_ms(47);
    chk({charge_en, status_oe}, 2'h3);
    wait_ms(6);
    chk({charge_en, status_oe}, 2'h0);
    @(posedge mclk);
    taper <= 1'b0;
    vbat_mv <= 13'd3800;
    wait_ms(160);
    chk({charge_en, status_oe}, 2'h3);
    $display("test start done");
  endtask
  task automatic t_short();
    boot(13'd3500, 1'b1);
    wait_ms(196);
    chk({charge_en, status_oe}, 2'h0);
    wait_ms(8);
    chk(current_req, CUR_FULL);
    $display("test short done");
  endtask
  task automatic t_trickle_err();
    logic [1:0] seen;
    seen = 2'h0;
    boot(13'd2000, 1'b0);
    wait_ms(154 + TRK - 20);
    chk({charge_en, status_oe}, 2'h3);
    wait_ms(28);
    chk({1'b0, charge_en}, 2'h0);
    repeat (12000) begin
      @(posedge mclk);
      if (status_oe === 1'b1) seen[1] = 1'b1;
      if (status_oe === 1'b0) seen[0] = 1'b1;
    end
    chk(seen, 2'h3);
    @(posedge mclk);
    vbat_mv <= 13'd3000;
    wait_ms(60);
    chk({1'b0, charge_en}, 2'h0);
    @(posedge mclk);
    power_good <= 1'b0;
    wait_ms(5);
    @(posedge mclk);
    power_good <= 1'b1;
    wait_ms(154);
    chk({charge_en, status_oe}, 2'h3);
    $display("test trickle error done");
  endtask
  task automatic t_main_err();
    boot(13'd3500, 1'b0);
    wait_ms(154 + MAIN - 20);
    chk({1'b0, charge_en}, 2'h1);
    wait_ms(30);
    chk({1'b0, charge_en}, 2'h0);
    $display("test main error done");
  endtask
  task automatic t_faults();
    boot(13'd3500, 1'b0);
    wait_ms(155);
    @(posedge mclk);
    vbat_mv <= 13'd4500;
    wait_ms(46);
    chk({1'b0, charge_en}, 2'h1);
    wait_ms(8);
    chk({1'b0, charge_en}, 2'h0);
    boot(13'd3500, 1'b0);
    wait_ms(155);
    @(posedge mclk);
    surge <= 1'b1;
    wait_ms(2);
    chk({1'b0, charge_en}, 2'h0);
    @(posedge mclk);
    surge <= 1'b0;
    $display("test faults done");
  endtask
  task automatic t_pause();
    boot(13'd3500, 1'b0);
    wait_ms(155);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      if (k == 0) temp_c <= -8'sd5;
      else die_hot <= 1'b1;
      wait_ms(46);
      chk(current_req, CUR_FULL);
      wait_ms(8);
      chk(current_req, CUR_OFF);
      chk({1'b0, status_oe}, 2'h1);
      @(posedge mclk);
      temp_c <= 8'sd25;
      die_hot <= 1'b0;
      wait_ms(54);
      chk(current_req, CUR_FULL);
    end
    // warm zone lowers the constant-voltage level, cool zone halves the current
    @(posedge mclk);
    temp_c <= 8'sd50;
    wait_ms(54);
    chk({1'b0, cv_low}, 2'h1);
    chk(current_req, CUR_FULL);
    @(posedge mclk);
    temp_c <= 8'sd5;
    wait_ms(54);
    chk({1'b0, cv_low}, 2'h0);
    chk(current_req, CUR_HALF);
    @(posedge mclk);
    temp_c <= 8'sd25;
    $display("test pause done");
  endtask
  // ======
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    wait_ms(2);
    chk({charge_en, status_oe}, 2'h0);
    chk(current_req, CUR_OFF);
    t_start();
    t_short();
    t_trickle_err();
    t_main_err();
    t_faults();
    t_pause();
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
